// ===== src/adc_ctrl_pkg.sv
// Purpose: constants and types shared by the converter control block
// Assumes: pclk at 20 MHz, host serial clock and select arrive as pins
// Notes:   register offsets are byte addresses of aligned 32-bit words
package adc_ctrl_pkg;

  localparam int PCLK_HZ = 20_000_000;
  localparam int OSC_HZ  = 2_000_000;
  localparam int OSC_DIV = PCLK_HZ / OSC_HZ;
  localparam int OSC_W   = 4;
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_DIV - 1);

  localparam int RES_BITS = 10;
  localparam int SUB_BITS = 2;
  localparam int SAR_BITS = RES_BITS + SUB_BITS;
  localparam int STEP_W   = 4;
  localparam logic [SAR_BITS-1:0] SAR_START = 12'h800;
  localparam logic [STEP_W-1:0]   SAR_TOP   = STEP_W'(SAR_BITS - 1);
  localparam logic [STEP_W-1:0]   SAR_LAST  = 4'h0;

  // frame positions count serial clock falling edges from one
  localparam int EDGE_W = 5;
  localparam logic [EDGE_W-1:0] EDGE_MAX        = 5'h1f;
  localparam logic [EDGE_W-1:0] FIRST_POS       = 5'h01;
  localparam logic [EDGE_W-1:0] LEAD_LAST_POS   = 5'h03;
  localparam logic [EDGE_W-1:0] TAG_POS         = 5'h04;
  localparam logic [EDGE_W-1:0] MSB_POS         = 5'h05;
  localparam logic [EDGE_W-1:0] LAST_POS        = 5'h10;
  localparam logic [EDGE_W-1:0] INT_SAMPLE_EDGE = 5'h01;
  localparam logic [EDGE_W-1:0] EXT_SAMPLE_EDGE = 5'h02;

  localparam int PADDR_W = 8;
  localparam logic [PADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [PADDR_W-1:0] STATUS_OFS = 8'h04;
  localparam logic [PADDR_W-1:0] RESULT_OFS = 8'h08;
  localparam int CTRL_PDIFF_BIT   = 0;
  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_MODE_BIT    = 1;
  localparam int STAT_CHAN_BIT    = 2;
  localparam int STAT_AWAKE_BIT   = 3;
  localparam int STAT_VALID_BIT   = 4;
  localparam int RESULT_TAG_BIT   = 16;
  localparam int RESULT_VALID_BIT = 31;
  localparam logic CTRL_PDIFF_RST = 1'b0;
  // select pin idles high, i.e. deselected
  localparam logic SEL_IDLE       = 1'b1;

  typedef enum logic [1:0] {
    st_off,
    st_acquire,
    st_convert,
    st_readout
  } conv_state_type;

endpackage

// ===== src/conv_osc.sv
// Purpose: on-chip conversion clock, one tick per oscillator period
// Assumes: run comes from a flip-flop on pclk
// Notes:   stopped and cleared whenever run is low
`timescale 1ns/1ps
module conv_osc (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      tick
);

  typedef struct packed {
    logic [adc_ctrl_pkg::OSC_W-1:0] cnt;
    logic                           tick;
  } osc_type;

  osc_type s_ff;
  osc_type nxt_s;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.tick = 1'b0;
    if (!run) begin
      nxt_s.cnt = '0;
    end else if (s_ff.cnt == adc_ctrl_pkg::OSC_LAST) begin
      nxt_s.cnt  = '0;
      nxt_s.tick = 1'b1;
    end else begin
      nxt_s.cnt = adc_ctrl_pkg::OSC_W'(s_ff.cnt + 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tick = s_ff.tick;

  osc_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_ff.tick |=> !s_ff.tick [*8])
    else $error("oscillator ticks closer than its period");

endmodule

// ===== src/sar_adc_ctrl.sv
// Purpose: sequencing, serial frame and register access of a 10-bit SAR
// Assumes: select, serial clock and comparator are asynchronous pins
// Notes:   serial clock edges are found by sampling; keep it well below pclk/4
`timescale 1ns/1ps
module sar_adc_ctrl (
  input  wire logic                              pclk,
  input  wire logic                              presetn,
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [adc_ctrl_pkg::PADDR_W-1:0]  paddr,
  input  wire logic [31:0]                       pwdata,
  output logic      [31:0]                       prdata,
  output logic                                   pready,
  output logic                                   pslverr,
  input  wire logic                              select_n_shutdown,
  input  wire logic                              sclk,
  input  wire logic                              comp_above,
  output logic                                   dout,
  output logic                                   dout_oe,
  output logic                                   track,
  output logic                                   powered,
  output logic      [adc_ctrl_pkg::SAR_BITS-1:0] dac_code,
  output logic                                   input_sel
);

  typedef struct packed {
    adc_ctrl_pkg::conv_state_type         state;
    logic                                 sclk_s1;
    logic                                 sclk_s2;
    logic                                 sclk_s3;
    logic                                 sel_s1;
    logic                                 sel_s2;
    logic                                 sel_s3;
    logic                                 comp_s1;
    logic                                 comp_s2;
    logic                                 mode_int;
    logic                                 chan_next;
    logic                                 chan_cur;
    logic                                 tag;
    logic                                 track;
    logic                                 powered;
    logic                                 dout;
    logic                                 dout_oe;
    logic [adc_ctrl_pkg::EDGE_W-1:0]      edge_cnt;
    logic [adc_ctrl_pkg::STEP_W-1:0]      step;
    logic [adc_ctrl_pkg::SAR_BITS-1:0]    trial;
    logic [adc_ctrl_pkg::SAR_BITS-1:0]    result;
    logic                                 result_tag;
    logic                                 result_valid;
    logic                                 pdiff;
    logic                                 pready;
    logic                                 pslverr;
    logic [31:0]                          prdata;
  } ctl_type;

  ctl_type s_ff;
  ctl_type nxt_s;

  logic                              osc_tick;
  logic                              sclk_fall;
  logic                              sel_fall;
  logic [adc_ctrl_pkg::SAR_BITS-1:0] decided;
  logic [adc_ctrl_pkg::EDGE_W-1:0]   cnt_inc;
  logic                              ext_data_pos;

  // only the second and third stages are compared, the first stays a pure synchroniser
  assign sclk_fall = s_ff.sclk_s3 & ~s_ff.sclk_s2;
  assign sel_fall  = s_ff.sel_s3 & ~s_ff.sel_s2;

  conv_osc u_osc (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (s_ff.state == adc_ctrl_pkg::st_convert),
    .tick    (osc_tick)
  );

  function automatic logic frame_bit(
    input logic [adc_ctrl_pkg::EDGE_W-1:0]   pos,
    input logic                              tag,
    input logic [adc_ctrl_pkg::SAR_BITS-1:0] res
  );
    logic b;
    b = 1'b0;
    if (pos >= adc_ctrl_pkg::FIRST_POS
        && pos <= adc_ctrl_pkg::LEAD_LAST_POS) begin
      b = 1'b1;
    end else if (pos == adc_ctrl_pkg::TAG_POS) begin
      b = tag;
    end else if (pos >= adc_ctrl_pkg::MSB_POS
                 && pos <= adc_ctrl_pkg::LAST_POS) begin
      b = res[adc_ctrl_pkg::STEP_W'(adc_ctrl_pkg::LAST_POS - pos)];
    end
    return b; // beyond the last sub-bit stays zero
  endfunction

  always_comb begin
    nxt_s   = s_ff;
    // one SAR step: keep the trial bit if the input is above it
    decided = s_ff.trial;
    decided[s_ff.step] = s_ff.comp_s2;
    if (s_ff.step != adc_ctrl_pkg::SAR_LAST) begin
      decided[adc_ctrl_pkg::STEP_W'(s_ff.step - 4'h1)] = 1'b1;
    end
    cnt_inc = (s_ff.edge_cnt == adc_ctrl_pkg::EDGE_MAX) ? s_ff.edge_cnt
            : adc_ctrl_pkg::EDGE_W'(s_ff.edge_cnt + 5'h01);
    ext_data_pos = (cnt_inc >= adc_ctrl_pkg::MSB_POS)
                 && (cnt_inc <= adc_ctrl_pkg::LAST_POS);

    nxt_s.sclk_s1 = sclk;
    nxt_s.sclk_s2 = s_ff.sclk_s1;
    nxt_s.sclk_s3 = s_ff.sclk_s2;
    nxt_s.sel_s1  = select_n_shutdown;
    nxt_s.sel_s2  = s_ff.sel_s1;
    nxt_s.sel_s3  = s_ff.sel_s2;
    nxt_s.comp_s1 = comp_above;
    nxt_s.comp_s2 = s_ff.comp_s1;
    nxt_s.dout_oe = ~s_ff.sel_s2;

    // register access: data fixed in setup, effects at the completing edge
    nxt_s.pready = psel & ~penable;
    if (psel && !penable) begin
      nxt_s.prdata  = '0;
      nxt_s.pslverr = 1'b0;
      case (paddr)
        adc_ctrl_pkg::CTRL_OFS: begin
          nxt_s.prdata[adc_ctrl_pkg::CTRL_PDIFF_BIT] = s_ff.pdiff;
        end
        adc_ctrl_pkg::STATUS_OFS: begin
          nxt_s.prdata[adc_ctrl_pkg::STAT_BUSY_BIT]  =
            (s_ff.state != adc_ctrl_pkg::st_off);
          nxt_s.prdata[adc_ctrl_pkg::STAT_MODE_BIT]  = s_ff.mode_int;
          nxt_s.prdata[adc_ctrl_pkg::STAT_CHAN_BIT]  = s_ff.chan_next;
          nxt_s.prdata[adc_ctrl_pkg::STAT_AWAKE_BIT] = s_ff.powered;
          nxt_s.prdata[adc_ctrl_pkg::STAT_VALID_BIT] = s_ff.result_valid;
        end
        adc_ctrl_pkg::RESULT_OFS: begin
          nxt_s.prdata[adc_ctrl_pkg::SAR_BITS-1:0]    = s_ff.result;
          nxt_s.prdata[adc_ctrl_pkg::RESULT_TAG_BIT]   = s_ff.result_tag;
          nxt_s.prdata[adc_ctrl_pkg::RESULT_VALID_BIT] = s_ff.result_valid;
        end
        default: begin
          nxt_s.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && s_ff.pready) begin
      if (pwrite && paddr == adc_ctrl_pkg::CTRL_OFS) begin
        nxt_s.pdiff = pwdata[adc_ctrl_pkg::CTRL_PDIFF_BIT];
      end
      // read of the result clears its valid flag; a new result set below wins
      if (!pwrite && paddr == adc_ctrl_pkg::RESULT_OFS) begin
        nxt_s.result_valid = 1'b0;
      end
    end

    if (s_ff.sel_s2) begin
      // deselected: shutdown, any running conversion is dropped
      nxt_s.state   = adc_ctrl_pkg::st_off;
      nxt_s.powered = 1'b0;
      nxt_s.track   = 1'b0;
      nxt_s.dout    = 1'b0;
    end else if (sel_fall) begin
      nxt_s.state    = adc_ctrl_pkg::st_acquire;
      nxt_s.powered  = 1'b1;
      nxt_s.track    = 1'b1;
      nxt_s.mode_int = s_ff.sclk_s2;
      nxt_s.edge_cnt = '0;
      nxt_s.dout     = 1'b0;
      nxt_s.trial    = '0;
      if (s_ff.pdiff) begin
        nxt_s.chan_cur = 1'b0;
        nxt_s.tag      = 1'b1;
      end else begin
        nxt_s.chan_cur  = s_ff.chan_next;
        nxt_s.tag       = s_ff.chan_next;
        nxt_s.chan_next = ~s_ff.chan_next;
      end
    end else begin
      unique case (s_ff.state)
        adc_ctrl_pkg::st_off: begin
        end
        adc_ctrl_pkg::st_acquire: begin
          if (sclk_fall) begin
            nxt_s.edge_cnt = cnt_inc;
            if (s_ff.mode_int) begin
              // first falling edge samples, oscillator takes over
              nxt_s.track = 1'b0;
              nxt_s.trial = adc_ctrl_pkg::SAR_START;
              nxt_s.step  = adc_ctrl_pkg::SAR_TOP;
              nxt_s.state = adc_ctrl_pkg::st_convert;
              nxt_s.dout  = 1'b0;
            end else begin
              nxt_s.dout = frame_bit(cnt_inc, s_ff.tag, s_ff.trial);
              if (cnt_inc == adc_ctrl_pkg::EXT_SAMPLE_EDGE) begin
                nxt_s.track = 1'b0;
                nxt_s.trial = adc_ctrl_pkg::SAR_START;
                nxt_s.step  = adc_ctrl_pkg::SAR_TOP;
                nxt_s.state = adc_ctrl_pkg::st_readout;
              end
            end
          end
        end
        adc_ctrl_pkg::st_convert: begin
          // serial clock edges here are ignored, data stays low
          if (osc_tick) begin
            nxt_s.trial = decided;
            nxt_s.step  = adc_ctrl_pkg::STEP_W'(s_ff.step - 4'h1);
            if (s_ff.step == adc_ctrl_pkg::SAR_LAST) begin
              nxt_s.state        = adc_ctrl_pkg::st_readout;
              nxt_s.dout         = 1'b1;
              nxt_s.edge_cnt     = adc_ctrl_pkg::INT_SAMPLE_EDGE;
              nxt_s.result       = decided;
              nxt_s.result_tag   = s_ff.tag;
              nxt_s.result_valid = 1'b1;
            end
          end
        end
        adc_ctrl_pkg::st_readout: begin
          if (sclk_fall) begin
            nxt_s.edge_cnt = cnt_inc;
            if (!s_ff.mode_int && ext_data_pos) begin
              // external clock steps the SAR and shows each bit at once
              nxt_s.trial = decided;
              nxt_s.step  = adc_ctrl_pkg::STEP_W'(s_ff.step - 4'h1);
              nxt_s.dout  = s_ff.comp_s2;
              if (s_ff.step == adc_ctrl_pkg::SAR_LAST) begin
                nxt_s.result       = decided;
                nxt_s.result_tag   = s_ff.tag;
                nxt_s.result_valid = 1'b1;
              end
            end else begin
              nxt_s.dout = frame_bit(cnt_inc, s_ff.tag, s_ff.trial);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff       <= '0;
      s_ff.pdiff <= adc_ctrl_pkg::CTRL_PDIFF_RST;
      // syncs start deselected, else dout_oe would pulse after reset
      s_ff.sel_s1 <= adc_ctrl_pkg::SEL_IDLE;
      s_ff.sel_s2 <= adc_ctrl_pkg::SEL_IDLE;
      s_ff.sel_s3 <= adc_ctrl_pkg::SEL_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata    = s_ff.prdata;
  assign pready    = s_ff.pready;
  assign pslverr   = s_ff.pslverr;
  assign dout      = s_ff.dout;
  assign dout_oe   = s_ff.dout_oe;
  assign track     = s_ff.track;
  assign powered   = s_ff.powered;
  assign dac_code  = s_ff.trial;
  assign input_sel = s_ff.chan_cur;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  dout_hiz_a: assert property (
    s_ff.sel_s2 ##1 s_ff.sel_s2 |=> !s_ff.dout_oe)
    else $error("data output driven while deselected");

  dout_edges_a: assert property (
    (s_ff.dout_oe && $past(s_ff.dout_oe) && $changed(s_ff.dout)
     && $past(s_ff.state) != adc_ctrl_pkg::st_off)
    |-> ($past(sclk_fall) || $past(s_ff.state) == adc_ctrl_pkg::st_convert))
    else $error("data output moved without a serial clock falling edge");

  shutdown_a: assert property (
    s_ff.sel_s2 |=> (s_ff.state == adc_ctrl_pkg::st_off) && !s_ff.powered
                    && !s_ff.track)
    else $error("circuitry left on while deselected");

  mode_latch_a: assert property (
    sel_fall |=> s_ff.mode_int == $past(s_ff.sclk_s2) && s_ff.track
                 && s_ff.powered)
    else $error("clock mode not taken from serial clock at select fall");

  chan_alt_a: assert property (
    (sel_fall && !s_ff.pdiff) |=> (s_ff.chan_next != $past(s_ff.chan_next))
                                  && (s_ff.tag == $past(s_ff.chan_next)))
    else $error("input did not alternate");

  int_sample_a: assert property (
    (s_ff.state == adc_ctrl_pkg::st_acquire && s_ff.mode_int && sclk_fall
     && !s_ff.sel_s2) |=> (s_ff.state == adc_ctrl_pkg::st_convert)
                          && !s_ff.track)
    else $error("internal mode did not sample on first falling edge");

  ext_sample_a: assert property (
    (s_ff.state == adc_ctrl_pkg::st_acquire && !s_ff.mode_int && sclk_fall
     && !s_ff.sel_s2)
    |=> s_ff.track == (s_ff.edge_cnt < adc_ctrl_pkg::EXT_SAMPLE_EDGE))
    else $error("external mode sampled on the wrong edge");

  conv_low_a: assert property (
    (s_ff.state == adc_ctrl_pkg::st_convert
     && $past(s_ff.state) == adc_ctrl_pkg::st_convert) |-> !s_ff.dout)
    else $error("data output high during internal conversion");

  eoc_high_a: assert property (
    (s_ff.state == adc_ctrl_pkg::st_readout
     && $past(s_ff.state) == adc_ctrl_pkg::st_convert)
    |-> s_ff.dout && s_ff.result_valid && !osc_tick)
    else $error("end of conversion not flagged high");

  lead_tag_a: assert property (
    (s_ff.state == adc_ctrl_pkg::st_readout && sclk_fall && !s_ff.sel_s2
     && cnt_inc == adc_ctrl_pkg::TAG_POS) |=> s_ff.dout == s_ff.tag)
    else $error("channel tag not in fourth frame position");

  trail_zero_a: assert property (
    (s_ff.state == adc_ctrl_pkg::st_readout && sclk_fall && !s_ff.sel_s2
     && s_ff.edge_cnt >= adc_ctrl_pkg::LAST_POS) |=> !s_ff.dout)
    else $error("nonzero bit after the last sub-bit");

endmodule

// ===== dv/host_link_model.sv
// Purpose: host serial master on the converter link, plus ideal comparator
// Assumes: link clock 400 ns, edges offset 13 ns from pclk edges
// Notes:   a released data line reads as the inverse of its last level
`timescale 1ns/1ps
module host_link_model (
  input  wire logic                              dout,
  input  wire logic                              dout_oe,
  input  wire logic                              track,
  input  wire logic                              powered,
  input  wire logic [adc_ctrl_pkg::SAR_BITS-1:0] dac_code,
  output logic                                   select_n_shutdown,
  output logic                                   sclk,
  output logic                                   comp_above
);
  logic [11:0] level;
  logic        last_dout;
  logic        pin;

  assign comp_above = (level >= dac_code);
  assign pin = dout_oe ? dout : ~last_dout;
  always @(dout or dout_oe) if (dout_oe) last_dout = dout;

  initial begin
    select_n_shutdown = 1'b1;
    sclk = 1'b0;
    level = 12'h000;
    last_dout = 1'b0;
  end

  // long low phase: the data output lags a fall by up to 3 pclk
  task automatic pulse(output logic b);
    sclk = 1'b0;
    #250;
    sclk = 1'b1;
    b = pin;
    #150;
  endtask

  // second select fall in a row skips the other input's turn
  task automatic blip();
    #13;
    select_n_shutdown = 1'b0;
    #150;
    select_n_shutdown = 1'b1;
    #150;
  endtask

  task automatic frame(input logic imode, input int nbits,
                       output logic [19:0] got, output logic [3:0] seen);
    int   k;
    logic b;
    got = 20'hx;
    seen = 4'hx;
    #13;
    sclk = imode;
    #150;
    select_n_shutdown = 1'b0;
    #3000;
    if (!imode) begin
      sclk = 1'b1;
      #150;
    end
    pulse(b);
    seen[0] = track;
    seen[1] = powered;
    seen[2] = b;
    if (imode) begin
      for (k = 0; k < 200 && pin !== 1'b1; k++) #50;
    end
    got[19] = pin;
    for (k = 2; k <= nbits; k++) begin
      pulse(b);
      got[20-k] = b;
      if (k == 2) seen[3] = track;
    end
    select_n_shutdown = 1'b1;
    #150;
  endtask
endmodule

// ===== dv/serial_sar_adc_control_bench.sv
// Purpose: self-checking bench of the converter control block
// Assumes: host model drives the link, bench drives APB
// Notes:   comparator is ideal, so the result equals the input level
`timescale 1ns/1ps
module serial_sar_adc_control_bench;
  logic                              pclk, presetn, psel, penable, pwrite;
  logic [adc_ctrl_pkg::PADDR_W-1:0]  paddr;
  logic [31:0]                       pwdata, prdata, rd;
  logic                              pready, pslverr, err, chan, pdiff;
  logic                              select_n_shutdown, sclk, comp_above;
  logic                              dout, dout_oe, track, powered;
  logic                              input_sel;
  logic [adc_ctrl_pkg::SAR_BITS-1:0] dac_code;
  logic [19:0]                       got;
  logic [3:0]                        seen;
  int                                fails, check_count, i;

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  sar_adc_ctrl sar_adc_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_n_shutdown(select_n_shutdown), .sclk(sclk),
    .comp_above(comp_above), .dout(dout), .dout_oe(dout_oe), .track(track),
    .powered(powered), .dac_code(dac_code), .input_sel(input_sel));

  host_link_model host_link_model_inst (.dout(dout), .dout_oe(dout_oe),
    .track(track), .powered(powered), .dac_code(dac_code),
    .select_n_shutdown(select_n_shutdown), .sclk(sclk),
    .comp_above(comp_above));

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 16; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 16) begin
      fails++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [19:0] exp_frame(logic tag, logic [11:0] lv);
    return {3'b111, tag, lv, 4'h0};
  endfunction

  task automatic run(input logic im, input logic [11:0] lv, input int nb);
    logic        tag;
    logic [19:0] m;
    tag = pdiff | chan;
    m = 20'hfffff >> nb;
    host_link_model_inst.level <= lv;
    @(posedge pclk);
    host_link_model_inst.frame(im, nb, got, seen);
    check(32'(got | m), 32'(exp_frame(tag, lv) | m));
    check(32'(seen[1]), 32'h1);
    check(32'(seen[0]), 32'(!im));
    if (im) check(32'(seen[2]), 32'h0);
    else check(32'(seen[3]), 32'h0);
    repeat (4) @(posedge pclk);
    check(32'(dout_oe), 32'h0);
    check(32'(powered), 32'h0);
    check(32'(input_sel), 32'(!pdiff & chan));
    if (nb >= 16) begin
      apb(1'b0, adc_ctrl_pkg::STATUS_OFS, 32'h0);
      check(rd, {27'h0, 1'b1, 1'b0, chan ^ !pdiff, im, 1'b0});
      apb(1'b0, adc_ctrl_pkg::RESULT_OFS, 32'h0);
      check(rd, {1'b1, 14'h0, tag, 4'h0, lv});
      apb(1'b0, adc_ctrl_pkg::RESULT_OFS, 32'h0);
      check(32'(rd[31]), 32'h0);
    end
    if (!pdiff) chan = ~chan;
  endtask

  initial begin
    #2_000_000;
    fails++;
    conclude();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    fails = 0;
    check_count = 0;
    chan = 1'b0;
    pdiff = 1'b0;
    void'($urandom(32'h56a17d97));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, adc_ctrl_pkg::STATUS_OFS, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h0c, 32'h5);
    check(32'(err), 32'h1);
    run(1'b0, 12'h000, 20);
    run(1'b1, 12'hfff, 20);
    run(1'b0, 12'h155, 8);
    run(1'b1, 12'h2aa, 1);
    run(1'b0, 12'h801, 16);
    @(posedge pclk);
    host_link_model_inst.blip();
    chan = ~chan;
    run(1'b1, 12'h3c5, 16);
    for (i = 0; i < 8; i++) begin
      run(1'($urandom), 12'($urandom), 16 + 4 * int'($urandom % 2));
    end
    apb(1'b1, adc_ctrl_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, adc_ctrl_pkg::CTRL_OFS, 32'h0);
    check(rd, 32'h1);
    pdiff = 1'b1;
    run(1'b0, 12'($urandom), 16);
    run(1'b1, 12'($urandom), 16);
    conclude();
  end
endmodule
